// >>> qec_defs.svh
`ifndef QEC_DEFS_SVH
`define QEC_DEFS_SVH
// Sizes
`define QEC_AXES 6
`define QEC_DW 32
`define QEC_AW 12
`define QEC_EVW 12
`define QEC_CTLW 4
// Control bits of each axis
`define QEC_CTL_STEP 0
`define QEC_CTL_ROUND 1
`define QEC_CTL_FALL 2
`define QEC_CTL_CLEAR 3
// Address fields
`define QEC_HI_MSB 11
`define QEC_HI_LSB 8
`define QEC_BLK_MSB 7
`define QEC_BLK_LSB 5
`define QEC_GLB_BLK 3'h0
`define QEC_AXIS_BLK0 3'h1
// Global register offsets
`define QEC_OFF_STATUS 5'h00
`define QEC_OFF_MASK 5'h04
`define QEC_OFF_ARM 5'h08
// Per-axis register offsets
`define QEC_OFF_CTRL 5'h00
`define QEC_OFF_CPR 5'h04
`define QEC_OFF_FLOOR 5'h08
`define QEC_OFF_COUNT 5'h0C
`define QEC_OFF_RAW 5'h10
`define QEC_OFF_VELO 5'h14
// Reset values and limits
`define QEC_FLOOR_RST 32'h0098_9680
`define QEC_TMR_MAX 32'hFFFF_FFFF
`define QEC_ONE 32'h0000_0001
`define QEC_MINUS_ONE 32'hFFFF_FFFF
`endif

// >>> qec_pkg.sv
`include "qec_defs.svh"
package qec_pkg;
	// State of one axis
	typedef struct packed {
		logic [2:0] sa;
		logic [2:0] sb;
		logic [2:0] si;
		logic fa;
		logic fb;
		logic fi;
		logic signed [`QEC_DW-1:0] count;
		logic signed [`QEC_DW-1:0] raw;
		logic [`QEC_DW-1:0] timer;
		logic [`QEC_DW-1:0] period;
		logic up;
		logic signed [`QEC_DW-1:0] velo;
		logic armed;
		logic idx_evt;
		logic perr;
	} qec_axis_s;
	// State of the register file
	typedef struct packed {
		logic [`QEC_EVW-1:0] status;
		logic [`QEC_EVW-1:0] mask;
		logic [`QEC_AXES-1:0][`QEC_CTLW-1:0] ctrl;
		logic [`QEC_AXES-1:0][`QEC_DW-1:0] cpr;
		logic [`QEC_AXES-1:0][`QEC_DW-1:0] vfloor;
		logic [`QEC_AXES-1:0] arm_set;
		logic [`QEC_DW-1:0] prdata;
		logic slverr;
	} qec_top_s;
endpackage

// >>> qec_axis_if.sv
`timescale 1ns/100ps
`include "qec_defs.svh"
interface qec_axis_if;
	logic step_mode;
	logic round_mode;
	logic idx_fall;
	logic clear;
	logic arm_set;
	logic signed [`QEC_DW-1:0] cpr;
	logic [`QEC_DW-1:0] vfloor;
	logic signed [`QEC_DW-1:0] count;
	logic signed [`QEC_DW-1:0] raw;
	logic signed [`QEC_DW-1:0] velo;
	logic armed;
	logic idx_evt;
	logic perr;
	modport ctl (output step_mode, round_mode, idx_fall, clear, arm_set, cpr, vfloor,
		input count, raw, velo, armed, idx_evt, perr);
	modport axis (input step_mode, round_mode, idx_fall, clear, arm_set, cpr, vfloor,
		output count, raw, velo, armed, idx_evt, perr);
endinterface

// >>> qec_axis.sv
`timescale 1ns/100ps
`include "qec_defs.svh"
module qec_axis (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pin_a,
	input wire logic pin_b,
	input wire logic pin_i,
	qec_axis_if.axis ax
);
	qec_pkg::qec_axis_s q;
	qec_pkg::qec_axis_s d;
	logic new_a, new_b, new_i, a_ch, b_ch, i_ch;
	logic step, up, idx_hit;
	logic signed [`QEC_DW-1:0] delta, half, adj, quo, rnd;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.sa = {q.sa[1:0], pin_a};
		d.sb = {q.sb[1:0], pin_b};
		d.si = {q.si[1:0], pin_i};
		new_a = (q.sa[1] == q.sa[2]) ? q.sa[2] : q.fa;
		new_b = (q.sb[1] == q.sb[2]) ? q.sb[2] : q.fb;
		new_i = (q.si[1] == q.si[2]) ? q.si[2] : q.fi;
		a_ch = new_a ^ q.fa;
		b_ch = new_b ^ q.fb;
		i_ch = new_i ^ q.fi;
		d.fa = new_a;
		d.fb = new_b;
		d.fi = new_i;
		// Count source select
		if (ax.step_mode) begin
			step = a_ch & new_a;
			up = new_b;
		end else begin
			step = a_ch ^ b_ch;
			up = a_ch ? (new_a ^ q.fb) : (new_b ~^ q.fa);
		end
		d.perr = ~ax.step_mode & a_ch & b_ch;
		delta = up ? `QEC_ONE : `QEC_MINUS_ONE;
		// Nearest multiple of counts between index
		half = ax.cpr >>> 1;
		adj = q.count[`QEC_DW-1] ? q.count - half : q.count + half;
		quo = (ax.cpr > 0) ? adj / ax.cpr : '0;
		rnd = (ax.cpr > 0) ? quo * ax.cpr : q.count;
		// Index edge, armed
		idx_hit = q.armed & i_ch & (new_i ^ ax.idx_fall);
		d.idx_evt = idx_hit;
		d.armed = ax.arm_set | (q.armed & ~idx_hit);
		// Counters
		if (step) begin
			d.raw = q.raw + delta;
		end
		if (ax.clear) begin
			d.count = '0;
		end else if (idx_hit) begin
			d.count = ax.round_mode ? rnd : '0;
		end else if (step) begin
			d.count = q.count + delta;
		end
		// Pulse interval timer
		if (step) begin
			d.period = q.timer;
			d.timer = `QEC_ONE;
			d.up = up;
		end else if (q.timer != `QEC_TMR_MAX) begin
			d.timer = q.timer + `QEC_ONE;
		end
		if (d.period == '0 || d.timer > ax.vfloor || d.period > ax.vfloor) begin
			d.velo = '0;
		end else begin
			d.velo = d.up ? $signed(d.period) : -$signed(d.period);
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Results
	assign ax.count = q.count;
	assign ax.raw = q.raw;
	assign ax.velo = q.velo;
	assign ax.armed = q.armed;
	assign ax.idx_evt = q.idx_evt;
	assign ax.perr = q.perr;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_pin_rise;
		$rose(pin_a) ##1 pin_a [*3];
	endsequence
	a_sync_filter: assert property (s_pin_rise |=> q.fa)
		else $error("phase A not filtered in time");
	a_clear_zero: assert property (ax.clear |=> q.count == 0)
		else $error("count not held at zero by clear");
	a_raw_follow: assert property (step |=> q.raw == $past(q.raw) + $past(delta))
		else $error("raw count missed an edge");
	a_step_count: assert property (ax.step_mode && a_ch && new_a |=>
		q.raw == $past(q.raw) + ($past(new_b) ? 1 : -1))
		else $error("step edge miscounted");
	a_quad_edge: assert property (!ax.step_mode && a_ch && !b_ch |=> q.raw != $past(q.raw))
		else $error("quadrature edge not counted");
	a_index_zero: assert property (idx_hit && !ax.round_mode && !ax.clear && !ax.arm_set |=>
		q.count == 0 && !q.armed)
		else $error("index reset failed");
	a_index_round: assert property (idx_hit && ax.round_mode && !ax.clear && ax.cpr > 0 |=>
		(q.count % $past(ax.cpr)) == 0)
		else $error("index round not a multiple");
	a_velo_floor: assert property (q.timer > $past(ax.vfloor) |-> q.velo == 0)
		else $error("velocity not zero below floor");
endmodule

// >>> qec_top.sv
`timescale 1ns/100ps
`include "qec_defs.svh"
// Behaviour
// - Six independent axis counters, each with A, B and index inputs.
// - Edges are counted continuously, whatever the host is doing.
// - While clear is set, the resettable count is held at zero.
// - Raw count follows every counted step; clear and index never touch it.
// - Resettable count is read as a signed 32-bit value.
// - Step mode: each A rise counts, direction from B level.
// - Quadrature mode decodes A and B as quadrature phases.
// - Armed index re-references once, then disarms until host arms again.
// - Armed with round select: count is rounded at index.
// - Armed without round select: count is zeroed at index.
// - Counts between index value is used only for rounding.
// - Index polarity bit chooses falling instead of rising index edge.
// - Velocity comes from timing the interval between pulses.
// - Velocity reads zero when slower than the configured floor.
module qec_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`QEC_AW-1:0] paddr,
	input wire logic [`QEC_DW-1:0] pwdata,
	output logic [`QEC_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`QEC_AXES-1:0] enc_a,
	input wire logic [`QEC_AXES-1:0] enc_b,
	input wire logic [`QEC_AXES-1:0] enc_idx,
	output logic irq
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	qec_pkg::qec_top_s q;
	qec_pkg::qec_top_s d;

	logic [`QEC_AXES-1:0][`QEC_DW-1:0] ax_count;
	logic [`QEC_AXES-1:0][`QEC_DW-1:0] ax_raw;
	logic [`QEC_AXES-1:0][`QEC_DW-1:0] ax_velo;
	logic [`QEC_AXES-1:0] ax_armed;
	logic [`QEC_AXES-1:0] ax_idx;
	logic [`QEC_AXES-1:0] ax_perr;

	logic setup;
	logic access;
	logic wr;
	logic hi_ok;
	logic glb;
	logic axsel;
	logic hit;
	logic [2:0] blk;
	logic [2:0] axn;
	logic [4:0] roff;
	logic [`QEC_DW-1:0] rd;
	logic [`QEC_EVW-1:0] ev;
	logic [`QEC_EVW-1:0] w1c;

	// ----------------------------------------
	// Axis counters
	// ----------------------------------------

	// One counter per axis, free running from the pins
	for (genvar n = 0; n < `QEC_AXES; n++) begin : g_axis
		qec_axis_if bus();

		// Configuration from the register file
		assign bus.step_mode = q.ctrl[n][`QEC_CTL_STEP];
		assign bus.round_mode = q.ctrl[n][`QEC_CTL_ROUND];
		assign bus.idx_fall = q.ctrl[n][`QEC_CTL_FALL];
		assign bus.clear = q.ctrl[n][`QEC_CTL_CLEAR];
		assign bus.arm_set = q.arm_set[n];
		assign bus.cpr = q.cpr[n];
		assign bus.vfloor = q.vfloor[n];

		// Results back to the register file
		assign ax_count[n] = bus.count;
		assign ax_raw[n] = bus.raw;
		assign ax_velo[n] = bus.velo;
		assign ax_armed[n] = bus.armed;
		assign ax_idx[n] = bus.idx_evt;
		assign ax_perr[n] = bus.perr;

		qec_axis u_axis (
			.clk(clk),
			.reset_n(reset_n),
			.pin_a(enc_a[n]),
			.pin_b(enc_b[n]),
			.pin_i(enc_idx[n]),
			.ax(bus.axis)
		);

		// An index event leaves the axis disarmed unless re-armed that cycle
		a_idx_disarm: assert property (@(posedge clk) disable iff (!reset_n)
			ax_idx[n] && !$past(q.arm_set[n]) |-> !ax_armed[n])
			else $error("axis still armed after index");
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------

	// Bus phases and register block select
	always_comb begin
		setup = psel & ~penable;
		access = psel & penable;
		wr = access & pwrite;
		blk = paddr[`QEC_BLK_MSB:`QEC_BLK_LSB];
		roff = paddr[`QEC_BLK_LSB-1:0];
		hi_ok = paddr[`QEC_HI_MSB:`QEC_HI_LSB] == '0;
		axn = blk - `QEC_AXIS_BLK0;
		glb = hi_ok && (blk == `QEC_GLB_BLK);
		axsel = hi_ok && (blk >= `QEC_AXIS_BLK0) && (axn < `QEC_AXES);
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------

	// Data for the addressed register, hit for a mapped one
	always_comb begin
		rd = '0;
		hit = 1'b0;
		if (glb) begin
			case (roff)
				`QEC_OFF_STATUS: begin
					rd[`QEC_EVW-1:0] = q.status;
					hit = 1'b1;
				end
				`QEC_OFF_MASK: begin
					rd[`QEC_EVW-1:0] = q.mask;
					hit = 1'b1;
				end
				`QEC_OFF_ARM: begin
					rd[`QEC_AXES-1:0] = ax_armed;
					hit = 1'b1;
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end else if (axsel) begin
			case (roff)
				`QEC_OFF_CTRL: begin
					rd[`QEC_CTLW-1:0] = q.ctrl[axn];
					hit = 1'b1;
				end
				`QEC_OFF_CPR: begin
					rd = q.cpr[axn];
					hit = 1'b1;
				end
				`QEC_OFF_FLOOR: begin
					rd = q.vfloor[axn];
					hit = 1'b1;
				end
				`QEC_OFF_COUNT: begin
					rd = ax_count[axn];
					hit = 1'b1;
				end
				`QEC_OFF_RAW: begin
					rd = ax_raw[axn];
					hit = 1'b1;
				end
				`QEC_OFF_VELO: begin
					rd = ax_velo[axn];
					hit = 1'b1;
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Register writes and events
	// ----------------------------------------

	// Writes land in the access phase, read data is caught in setup
	always_comb begin
		d = q;
		d.arm_set = '0;
		w1c = '0;
		ev = {ax_perr, ax_idx};
		if (wr && glb) begin
			case (roff)
				`QEC_OFF_STATUS: begin
					w1c = pwdata[`QEC_EVW-1:0];
				end
				`QEC_OFF_MASK: begin
					d.mask = pwdata[`QEC_EVW-1:0];
				end
				`QEC_OFF_ARM: begin
					d.arm_set = pwdata[`QEC_AXES-1:0];
				end
				default: begin
					d.mask = q.mask;
				end
			endcase
		end
		if (wr && axsel) begin
			case (roff)
				`QEC_OFF_CTRL: begin
					d.ctrl[axn] = pwdata[`QEC_CTLW-1:0];
				end
				`QEC_OFF_CPR: begin
					d.cpr[axn] = pwdata;
				end
				`QEC_OFF_FLOOR: begin
					d.vfloor[axn] = pwdata;
				end
				default: begin
					d.ctrl = q.ctrl;
				end
			endcase
		end
		// Sticky events, a new event beats a clear
		d.status = (q.status & ~w1c) | ev;
		if (setup) begin
			d.prdata = rd;
			d.slverr = ~hit;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= '0;
			q.vfloor <= {`QEC_AXES{`QEC_FLOOR_RST}};
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------

	// Zero wait states, error only in the access phase
	assign pready = 1'b1;
	assign prdata = q.prdata;
	assign pslverr = access & q.slverr;

	// Level interrupt from unmasked sticky bits
	assign irq = |(q.status & q.mask);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_bad_setup;
		setup && !hit;
	endsequence

	sequence s_arm_write;
		wr && glb && (roff == `QEC_OFF_ARM) && (pwdata[`QEC_AXES-1:0] != '0);
	endsequence

	a_unmapped_err: assert property (s_bad_setup ##1 access |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	a_arm_take: assert property (s_arm_write |=> ##1
		(ax_armed & $past(pwdata[`QEC_AXES-1:0], 2)) == $past(pwdata[`QEC_AXES-1:0], 2))
		else $error("arm write did not arm axis");
	a_event_wins: assert property (wr && glb && (roff == `QEC_OFF_STATUS) && |(ev & pwdata[`QEC_EVW-1:0]) |=>
		(q.status & $past(ev & pwdata[`QEC_EVW-1:0])) == $past(ev & pwdata[`QEC_EVW-1:0]))
		else $error("event lost under clear");
	a_w1c_clear: assert property (wr && glb && (roff == `QEC_OFF_STATUS) && ev == '0 |=>
		(q.status & $past(pwdata[`QEC_EVW-1:0])) == '0)
		else $error("status bit not cleared");

	sequence s_good_setup;
		setup && hit;
	endsequence

	sequence s_mask_write;
		wr && glb && (roff == `QEC_OFF_MASK);
	endsequence

	// A mapped access completes without error
	a_mapped_ok: assert property (s_good_setup ##1 access |-> !pslverr)
		else $error("mapped access flagged as error");

	// Read data is caught at the setup edge
	a_read_take: assert property (setup |=> prdata == $past(rd))
		else $error("read data not caught at setup");

	// Read data and error flag hold until the next setup
	a_read_hold: assert property (!setup |=> $stable(prdata) && $stable(q.slverr))
		else $error("read data moved outside setup");

	// Resettable count read back as the full signed word
	a_count_read: assert property (setup && axsel && (roff == `QEC_OFF_COUNT) |=>
		prdata == $past(ax_count[axn]))
		else $error("count read does not match axis");

	// Raw count read back unchanged
	a_raw_read: assert property (setup && axsel && (roff == `QEC_OFF_RAW) |=>
		prdata == $past(ax_raw[axn]))
		else $error("raw read does not match axis");

	// Mask write lands at the access edge
	a_mask_write: assert property (s_mask_write |=> q.mask == $past(pwdata[`QEC_EVW-1:0]))
		else $error("mask write lost");

	// Control word of the addressed axis takes the written bits
	a_ctrl_write: assert property (wr && axsel && (roff == `QEC_OFF_CTRL) |=>
		q.ctrl[$past(axn)] == $past(pwdata[`QEC_CTLW-1:0]))
		else $error("control write lost");

	// Counts between index is stored as written
	a_cpr_write: assert property (wr && axsel && (roff == `QEC_OFF_CPR) |=>
		q.cpr[$past(axn)] == $past(pwdata))
		else $error("counts between index write lost");

	// Velocity floor is stored as written
	a_floor_write: assert property (wr && axsel && (roff == `QEC_OFF_FLOOR) |=>
		q.vfloor[$past(axn)] == $past(pwdata))
		else $error("velocity floor write lost");

	// Result registers are read only; writes there change no setting
	a_ro_ignore: assert property (wr && axsel && (roff >= `QEC_OFF_COUNT) |=>
		$stable(q.ctrl) && $stable(q.cpr) && $stable(q.vfloor))
		else $error("write to result register changed a setting");

	// Refused writes change nothing and arm nothing
	a_bad_nowrite: assert property (wr && !glb && !axsel |=>
		$stable(q.mask) && $stable(q.ctrl) && $stable(q.cpr) && $stable(q.vfloor) && q.arm_set == '0)
		else $error("refused write changed state");

	// Status bits only drop under a status write
	a_status_hold: assert property (!(wr && glb && (roff == `QEC_OFF_STATUS)) |=>
		(q.status & $past(q.status)) == $past(q.status))
		else $error("status bit dropped without clear");

	// Every event sets its status bit
	a_event_set: assert property (ev != '0 |=> (q.status & $past(ev)) == $past(ev))
		else $error("event not latched in status");

	// Arm request is a single cycle pulse
	a_arm_pulse: assert property (!(wr && glb && (roff == `QEC_OFF_ARM)) |=> q.arm_set == '0)
		else $error("arm request outlived its write");
endmodule

// >>> qec_enc_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Encoder signal source for six axes
// ----------------------------------------
module qec_enc_model (
	input wire logic clk,
	output logic [5:0] enc_a,
	output logic [5:0] enc_b,
	output logic [5:0] enc_idx
);
	logic [1:0] ph [6];

	// Idle levels at time zero
	initial begin
		enc_a = 6'h00;
		enc_b = 6'h00;
		enc_idx = 6'h00;
		for (int i = 0; i < 6; i++) begin
			ph[i] = 2'h0;
		end
	end

	// Quadrature steps, A leads B when moving up; one pin changes per step
	task automatic quad(input int ax, input int n, input logic up, input int gap);
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			ph[ax] = up ? ph[ax] + 2'h1 : ph[ax] - 2'h1;
			enc_a[ax] <= ph[ax][0] ^ ph[ax][1];
			enc_b[ax] <= ph[ax][1];
			repeat (gap) @(posedge clk);
		end
	endtask

	// Step pulse on A, direction level on B set up first
	task automatic step(input int ax, input logic up, input int gap);
		@(posedge clk);
		enc_b[ax] <= up;
		repeat (gap) @(posedge clk);
		enc_a[ax] <= 1'b1;
		repeat (gap) @(posedge clk);
		enc_a[ax] <= 1'b0;
		repeat (gap) @(posedge clk);
	endtask

	// Both phases at once, a quadrature step that must be refused
	task automatic both(input int ax);
		@(posedge clk);
		enc_a[ax] <= ~enc_a[ax];
		enc_b[ax] <= ~enc_b[ax];
		repeat (6) @(posedge clk);
	endtask

	// Index level held long enough to pass the synchroniser
	task automatic idx(input int ax, input logic lvl);
		@(posedge clk);
		enc_idx[ax] <= lvl;
		repeat (6) @(posedge clk);
	endtask
endmodule

// >>> quadrature_encoder_counter_tb.sv
`timescale 1ns/100ps
`include "qec_defs.svh"
module quadrature_encoder_counter_tb;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [`QEC_AW-1:0] paddr;
	logic [`QEC_DW-1:0] pwdata, prdata, rd;
	logic [`QEC_AXES-1:0] enc_a, enc_b, enc_idx;
	int err_count, samples_checked;

	// ----------------------------------------
	// Instances
	// ----------------------------------------
	qec_top dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx), .irq(irq));
	qec_enc_model mdl_u (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [`QEC_DW-1:0] seen, input logic [`QEC_DW-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; held until pready is seen high at an access edge
	task automatic apb(input logic wr, input logic [`QEC_AW-1:0] a, input logic [`QEC_DW-1:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			end_sim();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic rdchk(input logic [`QEC_AW-1:0] a, input logic [`QEC_DW-1:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	function automatic logic [`QEC_AW-1:0] ax(input int n, input logic [`QEC_AW-1:0] off);
		return `QEC_AW'(32 * (n + 1)) + off;
	endfunction

	// ----------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		end_sim();
	end

	// Main sequence
	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		err_count = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		rdchk(ax(0, 12'h008), `QEC_FLOOR_RST);
		rdchk(12'h000, 32'h0000_0000);
		// Quadrature on axis 0 and 5, velocity from pulse interval
		mdl_u.quad(0, 8, 1'b1, 4);
		mdl_u.quad(0, 3, 1'b0, 4);
		rdchk(ax(0, 12'h014), 32'hFFFF_FFFB);
		chk({31'h0, rd[31]}, 32'h0000_0001);
		mdl_u.quad(5, 4, 1'b1, 4);
		rdchk(ax(0, 12'h00C), 32'h0000_0005);
		rdchk(ax(5, 12'h00C), 32'h0000_0004);
		rdchk(ax(3, 12'h010), 32'h0000_0000);
		rdchk(ax(5, 12'h014), 32'h0000_0005);
		apb(1'b1, ax(5, 12'h008), 32'h0000_0020);
		repeat (40) @(posedge clk);
		rdchk(ax(5, 12'h014), 32'h0000_0000);
		apb(1'b1, ax(5, 12'h00C), 32'h0000_0055);
		rdchk(ax(5, 12'h00C), 32'h0000_0004);
		// Step and direction on axis 1
		apb(1'b1, ax(1, 12'h000), 32'h0000_0001);
		for (int i = 0; i < 3; i++) begin
			mdl_u.step(1, 1'b1, 3);
		end
		mdl_u.step(1, 1'b0, 3);
		rdchk(ax(1, 12'h00C), 32'h0000_0002);
		// Clear holds count, raw keeps counting
		apb(1'b1, ax(0, 12'h000), 32'h0000_0008);
		mdl_u.quad(0, 2, 1'b1, 4);
		rdchk(ax(0, 12'h00C), 32'h0000_0000);
		rdchk(ax(0, 12'h010), 32'h0000_0007);
		apb(1'b1, ax(0, 12'h000), 32'h0000_0000);
		// Armed index zeroes, disarms, raises interrupt
		apb(1'b1, 12'h004, 32'h0000_0001);
		mdl_u.quad(0, 3, 1'b1, 4);
		apb(1'b1, 12'h008, 32'h0000_0001);
		rdchk(12'h008, 32'h0000_0001);
		mdl_u.idx(0, 1'b1);
		mdl_u.idx(0, 1'b0);
		rdchk(ax(0, 12'h00C), 32'h0000_0000);
		rdchk(12'h008, 32'h0000_0000);
		rdchk(12'h000, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b1, 12'h004, 32'h0000_0000);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		apb(1'b1, 12'h004, 32'h0000_0001);
		apb(1'b1, 12'h000, 32'h0000_0001);
		rdchk(12'h000, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		// Both phases at once on axis 3: refused, flagged, masked off
		mdl_u.both(3);
		mdl_u.both(3);
		rdchk(12'h000, 32'h0000_0200);
		rdchk(ax(3, 12'h010), 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		rdchk(ax(0, 12'h010), 32'h0000_000A);
		// Round to nearest multiple, then an unarmed index does nothing
		apb(1'b1, ax(0, 12'h000), 32'h0000_0002);
		apb(1'b1, ax(0, 12'h004), 32'h0000_0008);
		mdl_u.quad(0, 7, 1'b1, 4);
		apb(1'b1, 12'h008, 32'h0000_0001);
		mdl_u.idx(0, 1'b1);
		mdl_u.idx(0, 1'b0);
		rdchk(ax(0, 12'h00C), 32'h0000_0008);
		chk(rd / 32'h0000_0004, 32'h0000_0002);
		mdl_u.quad(0, 1, 1'b1, 4);
		mdl_u.idx(0, 1'b1);
		mdl_u.idx(0, 1'b0);
		rdchk(ax(0, 12'h00C), 32'h0000_0009);
		// Falling index polarity
		apb(1'b1, ax(0, 12'h000), 32'h0000_0004);
		apb(1'b1, 12'h008, 32'h0000_0001);
		mdl_u.idx(0, 1'b1);
		rdchk(12'h008, 32'h0000_0001);
		mdl_u.idx(0, 1'b0);
		rdchk(12'h008, 32'h0000_0000);
		rdchk(ax(0, 12'h00C), 32'h0000_0000);
		// Unmapped address is refused
		apb(1'b0, 12'h100, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		apb(1'b1, 12'h100, 32'h0000_00FF);
		chk({31'h0, err}, 32'h0000_0001);
		end_sim();
	end
endmodule
